// ---- design/ext_bus_pins_map.svh ----
`ifndef EXT_BUS_PINS_MAP_SVH
`define EXT_BUS_PINS_MAP_SVH
// bus mode codes
`define BUS_MODE_NONE 2'h0
`define BUS_MODE_DEMUX 2'h1
`define BUS_MODE_MUX 2'h2
// byte halves of a 16-bit port
`define LOW_LSB 0
`define LOW_MSB 7
`define HIGH_LSB 8
`define HIGH_MSB 15
`define ALL_ZERO_16 16'h0000
`define ALL_ONE_16 16'hffff
`endif

// ---- design/ext_bus_pins_pkg.sv ----
`default_nettype none
package ext_bus_pins_pkg;
    // external bus configuration
    typedef enum logic [1:0] {
        MODE_NONE = 2'b00,
        MODE_DEMUX = 2'b01,
        MODE_MUX = 2'b10
    } bus_mode_t;
    typedef struct packed {
        logic [1:0] mode; // bus mode code
        logic wide; // 1: 16-bit data path
    } bus_cfg_t;
    // one bus cycle request from the bus controller
    typedef struct packed {
        logic [15:0] addr; // address bits 0..15
        logic [15:0] wdata; // write data
        logic addr_phase; // mux mode: address time slot
        logic drive_data; // write data phase
        logic high_byte; // upper byte involved
    } bus_req_t;
endpackage
`default_nettype wire

// ---- design/external_bus_port_pin_mux.sv ----
// How it works
// - every pin has own direction bit
// - input pin means driver disabled, high-z
// - bus mode takes addr_data_port from gpio
// - demux: low data, high data if wide
// - mux: low shared, high address or shared
// - demux: address_port drives 16-bit address
// - address_port keeps address after demux-to-mux
// - high_byte_enable output for wide accesses
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_pins_map.svh"
module external_bus_port_pin_mux #(
    parameter int PORT_W = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire ext_bus_pins_pkg::bus_cfg_t i_bus_cfg,
    input wire ext_bus_pins_pkg::bus_req_t i_bus_req,
    input wire logic [PORT_W-1:0] i_gpio0_out,
    input wire logic [PORT_W-1:0] i_gpio0_dir,
    input wire logic [PORT_W-1:0] i_gpio1_out,
    input wire logic [PORT_W-1:0] i_gpio1_dir,
    input wire logic [PORT_W-1:0] i_addr_data_port_in,
    input wire logic [PORT_W-1:0] i_address_port_in,
    output logic [PORT_W-1:0] o_addr_data_port_out,
    output logic [PORT_W-1:0] o_addr_data_port_oe,
    output logic [PORT_W-1:0] o_address_port_out,
    output logic [PORT_W-1:0] o_address_port_oe,
    output logic [PORT_W-1:0] o_addr_data_port_sync,
    output logic [PORT_W-1:0] o_address_port_sync,
    output logic [PORT_W-1:0] o_bus_rdata,
    output logic o_high_byte_enable_n
);
    // mode decodes
    wire logic is_demux; // demultiplexed bus selected
    wire logic is_mux; // multiplexed bus selected
    assign is_demux = (i_bus_cfg.mode == `BUS_MODE_DEMUX);
    assign is_mux = (i_bus_cfg.mode == `BUS_MODE_MUX);

    // remembers that address_port was taken by a demux mode
    logic addr_hold_ff;
    logic nxt_addr_hold;
    assign nxt_addr_hold = is_demux | (is_mux & addr_hold_ff);

    // address_port is an address bus while this is high
    wire logic p1_is_addr;
    assign p1_is_addr = is_demux | (is_mux & addr_hold_ff);

    // per-half function of addr_data_port
    wire logic ad_low_bus;
    wire logic ad_high_bus;
    assign ad_low_bus = is_demux | is_mux;
    assign ad_high_bus = is_mux | (is_demux & i_bus_cfg.wide);

    // bus-side value and enable per half of addr_data_port
    wire logic [PORT_W-1:0] p0_bus_val;
    wire logic [PORT_W-1:0] p0_bus_oe;
    // mux: address slot drives addr; mux 8-bit high half always addr
    wire logic ad_high_addr_only;
    assign ad_high_addr_only = is_mux & ~i_bus_cfg.wide;
    assign p0_bus_val[`LOW_MSB:`LOW_LSB] = (is_mux & i_bus_req.addr_phase) ?
        i_bus_req.addr[`LOW_MSB:`LOW_LSB] : i_bus_req.wdata[`LOW_MSB:`LOW_LSB];
    assign p0_bus_val[`HIGH_MSB:`HIGH_LSB] =
        ((is_mux & i_bus_req.addr_phase) | ad_high_addr_only) ?
        i_bus_req.addr[`HIGH_MSB:`HIGH_LSB] : i_bus_req.wdata[`HIGH_MSB:`HIGH_LSB];
    // drive during address slot or write data; float for reads except the mux 8-bit high half
    wire logic low_drv;
    wire logic high_drv;
    assign low_drv = (is_mux & i_bus_req.addr_phase) | i_bus_req.drive_data;
    assign high_drv = ad_high_addr_only | low_drv;
    assign p0_bus_oe[`LOW_MSB:`LOW_LSB] = {8{low_drv}};
    assign p0_bus_oe[`HIGH_MSB:`HIGH_LSB] = {8{high_drv}};

    // per-pin selection, gpio direction bit is the enable (1 = output)
    wire logic [PORT_W-1:0] nxt_p0_out;
    wire logic [PORT_W-1:0] nxt_p0_oe;
    wire logic [PORT_W-1:0] nxt_p1_out;
    wire logic [PORT_W-1:0] nxt_p1_oe;
    genvar g;
    generate
        for (g = 0; g < PORT_W; g++) begin : g_pin
            wire logic own_bus;
            assign own_bus = (g <= `LOW_MSB) ? ad_low_bus : ad_high_bus;
            assign nxt_p0_out[g] = own_bus ? p0_bus_val[g] : i_gpio0_out[g];
            assign nxt_p0_oe[g] = own_bus ? p0_bus_oe[g] : i_gpio0_dir[g];
            assign nxt_p1_out[g] = p1_is_addr ? i_bus_req.addr[g] : i_gpio1_out[g];
            assign nxt_p1_oe[g] = p1_is_addr | i_gpio1_dir[g];
        end
    endgenerate

    // high byte enable: active low, for wide accesses touching upper byte
    wire logic nxt_hbe_n;
    assign nxt_hbe_n = ~((is_demux | is_mux) & i_bus_cfg.wide & i_bus_req.high_byte);

    // pin input synchronisers, three stages
    logic [PORT_W-1:0] p0_s1_ff, p0_s2_ff, p0_s3_ff;
    logic [PORT_W-1:0] p1_s1_ff, p1_s2_ff, p1_s3_ff;
    // accepted input: update a bit once stage two and three agree
    wire logic [PORT_W-1:0] p0_agree;
    wire logic [PORT_W-1:0] p1_agree;
    assign p0_agree = ~(p0_s2_ff ^ p0_s3_ff);
    assign p1_agree = ~(p1_s2_ff ^ p1_s3_ff);
    wire logic [PORT_W-1:0] nxt_p0_sync;
    wire logic [PORT_W-1:0] nxt_p1_sync;
    assign nxt_p0_sync = (p0_agree & p0_s3_ff) | (~p0_agree & o_addr_data_port_sync);
    assign nxt_p1_sync = (p1_agree & p1_s3_ff) | (~p1_agree & o_address_port_sync);
    // read data: narrow bus fills upper byte with zeros
    wire logic [PORT_W-1:0] nxt_rdata;
    assign nxt_rdata = i_bus_cfg.wide ? nxt_p0_sync :
        {8'h00, nxt_p0_sync[`LOW_MSB:`LOW_LSB]};

    // synchroniser chain; pins come from outside the clock domain
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            p0_s1_ff <= `ALL_ZERO_16;
            p0_s2_ff <= `ALL_ZERO_16;
            p0_s3_ff <= `ALL_ZERO_16;
            p1_s1_ff <= `ALL_ZERO_16;
            p1_s2_ff <= `ALL_ZERO_16;
            p1_s3_ff <= `ALL_ZERO_16;
        end else begin
            p0_s1_ff <= i_addr_data_port_in;
            p0_s2_ff <= p0_s1_ff;
            p0_s3_ff <= p0_s2_ff;
            p1_s1_ff <= i_address_port_in;
            p1_s2_ff <= p1_s1_ff;
            p1_s3_ff <= p1_s2_ff;
        end
    end

    // registered pin drive; reset leaves every pin as input
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            addr_hold_ff <= 1'b0;
            o_addr_data_port_out <= `ALL_ZERO_16;
            o_addr_data_port_oe <= `ALL_ZERO_16;
            o_address_port_out <= `ALL_ZERO_16;
            o_address_port_oe <= `ALL_ZERO_16;
            o_high_byte_enable_n <= 1'b1;
        end else begin
            addr_hold_ff <= nxt_addr_hold;
            o_addr_data_port_out <= nxt_p0_out;
            o_addr_data_port_oe <= nxt_p0_oe;
            o_address_port_out <= nxt_p1_out;
            o_address_port_oe <= nxt_p1_oe;
            o_high_byte_enable_n <= nxt_hbe_n;
        end
    end

    // accepted input values
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_addr_data_port_sync <= `ALL_ZERO_16;
            o_address_port_sync <= `ALL_ZERO_16;
            o_bus_rdata <= `ALL_ZERO_16;
        end else begin
            o_addr_data_port_sync <= nxt_p0_sync;
            o_address_port_sync <= nxt_p1_sync;
            o_bus_rdata <= nxt_rdata;
        end
    end

    // checks; armed one edge after reset leaves, because on the edge where
    // reset falls the outputs still hold reset values and must not be judged
    logic live_ff; // high from the second edge after reset
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            live_ff <= 1'b0;
        end else begin
            live_ff <= 1'b1;
        end
    end
    // current-value disable, so a mid-run reset aborts open attempts at once
    wire logic chk_off;
    assign chk_off = i_sys_rst | ~live_ff;

    // general i/o
    gpio_hiz_a: assert property (@(posedge i_clk_sys) disable iff (chk_off)
        (i_bus_cfg.mode == `BUS_MODE_NONE && i_gpio0_dir == `ALL_ZERO_16)
        |=> (o_addr_data_port_oe == `ALL_ZERO_16)) else $error("gpio input driven");
    gpio_follow_a: assert property (@(posedge i_clk_sys) disable iff (chk_off)
        (i_bus_cfg.mode == `BUS_MODE_NONE) |=> (o_address_port_oe == $past(i_gpio1_dir)
        && o_addr_data_port_out == $past(i_gpio0_out))) else $error("gpio not per pin");
    // demultiplexed bus
    demux_addr_a: assert property (@(posedge i_clk_sys) disable iff (chk_off)
        (i_bus_cfg.mode == `BUS_MODE_DEMUX) |=> (o_address_port_oe == `ALL_ONE_16
        && o_address_port_out == $past(i_bus_req.addr))) else $error("no demux addr");
    hold_addr_a: assert property (@(posedge i_clk_sys) disable iff (chk_off)
        (i_bus_cfg.mode == `BUS_MODE_DEMUX) ##1 (i_bus_cfg.mode == `BUS_MODE_MUX)
        |=> (o_address_port_oe == `ALL_ONE_16)) else $error("addr lost on switch");
    demux_narrow_a: assert property (@(posedge i_clk_sys) disable iff (chk_off)
        (is_demux && !i_bus_cfg.wide) |=> (o_addr_data_port_oe[`HIGH_MSB:`HIGH_LSB]
        == $past(i_gpio0_dir[`HIGH_MSB:`HIGH_LSB]))) else $error("high half not gpio");
    demux_data_a: assert property (@(posedge i_clk_sys) disable iff (chk_off)
        (is_demux && i_bus_req.drive_data) |=> (o_addr_data_port_out[`LOW_MSB:`LOW_LSB]
        == $past(i_bus_req.wdata[`LOW_MSB:`LOW_LSB]))) else $error("demux data wrong");
    demux_wide_a: assert property (@(posedge i_clk_sys) disable iff (chk_off)
        (is_demux && i_bus_cfg.wide && i_bus_req.drive_data) |=> (o_addr_data_port_oe
        == `ALL_ONE_16 && o_addr_data_port_out == $past(i_bus_req.wdata))) else $error("wide data");
    // multiplexed bus, and wide reads in either bus mode
    mux_addr_a: assert property (@(posedge i_clk_sys) disable iff (chk_off)
        (is_mux && i_bus_req.addr_phase) |=> (o_addr_data_port_out == $past(i_bus_req.addr)
        && o_addr_data_port_oe == `ALL_ONE_16)) else $error("mux addr slot wrong");
    mux_high_a: assert property (@(posedge i_clk_sys) disable iff (chk_off)
        (is_mux && !i_bus_cfg.wide) |=> ((&o_addr_data_port_oe[`HIGH_MSB:`HIGH_LSB]) &&
        o_addr_data_port_out[`HIGH_MSB:`HIGH_LSB] == $past(i_bus_req.addr[`HIGH_MSB:`HIGH_LSB])))
        else $error("mux high half not address");
    read_float_a: assert property (@(posedge i_clk_sys) disable iff (chk_off)
        ((is_demux || is_mux) && i_bus_cfg.wide && !i_bus_req.addr_phase && !i_bus_req.drive_data)
        |=> (o_addr_data_port_oe == `ALL_ZERO_16)) else $error("read slot driven");
    // byte enable, read data, configuration
    high_byte_a: assert property (@(posedge i_clk_sys) disable iff (chk_off)
        (!o_high_byte_enable_n) |-> $past(i_bus_cfg.wide && i_bus_req.high_byte))
        else $error("high byte enable spurious");
    high_byte_on_a: assert property (@(posedge i_clk_sys) disable iff (chk_off)
        ((is_demux || is_mux) && i_bus_cfg.wide && i_bus_req.high_byte)
        |=> (!o_high_byte_enable_n)) else $error("high byte enable missing");
    rdata_narrow_a: assert property (@(posedge i_clk_sys) disable iff (chk_off)
        (!i_bus_cfg.wide) |=> (~|o_bus_rdata[`HIGH_MSB:`HIGH_LSB]))
        else $error("narrow read upper byte set");
    none_gpio_a: assert property (@(posedge i_clk_sys) disable iff (chk_off)
        (i_bus_cfg.mode == `BUS_MODE_NONE) [*2] |-> !addr_hold_ff)
        else $error("hold without bus");
endmodule
`default_nettype wire

// ---- sim/ext_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// external memory on the demux bus; no array, read word is derived from the address
module ext_mem_model (
    input wire logic i_clk_sys,
    input wire logic [15:0] i_ad_out,
    input wire logic [15:0] i_ad_oe,
    input wire logic [15:0] i_a_out,
    input wire logic [15:0] i_a_oe,
    output logic [15:0] o_ad_pin,
    output logic [15:0] o_a_pin
);
    logic [15:0] ad_last_ff = 16'h0000; // last driven data level
    logic [15:0] a_last_ff = 16'h0000; // last driven address level
    // answers only when the device floats all data pins and drives the address
    wire mem_drive = (i_ad_oe == 16'h0000) && (i_a_oe == 16'hffff);
    wire [15:0] rd_word = i_a_out ^ 16'h5a5a;
    // released lines show the inverse of their last level, or rd_word on data lines while the memory answers
    assign o_ad_pin = (i_ad_oe & i_ad_out) | (~i_ad_oe & (mem_drive ? rd_word : ~ad_last_ff));
    assign o_a_pin = (i_a_oe & i_a_out) | (~i_a_oe & ~a_last_ff);
    // remember driven levels only
    always_ff @(posedge i_clk_sys) begin
        ad_last_ff <= (i_ad_oe & i_ad_out) | (~i_ad_oe & ad_last_ff);
        a_last_ff <= (i_a_oe & i_a_out) | (~i_a_oe & a_last_ff);
    end
endmodule
`default_nettype wire

// ---- sim/external_bus_port_pin_mux_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module external_bus_port_pin_mux_tb;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    ext_bus_pins_pkg::bus_cfg_t cfg = 3'h0; // {mode, wide}
    ext_bus_pins_pkg::bus_req_t req = 35'h0;
    logic [63:0] gp = 64'h0; // gpio out/dir of both ports
    logic [15:0] ado, adoe, ao, aoe, ads, as_s, rd, adp, ap;
    logic hbe_n;
    logic hold_m = 1'b0; // bench copy of the address hold
    int err_total = 0;
    int n_checks = 0;
    always #50 i_clk_sys = ~i_clk_sys;
    external_bus_port_pin_mux u_dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_bus_cfg(cfg), .i_bus_req(req), .i_gpio0_out(gp[63:48]), .i_gpio0_dir(gp[47:32]),
        .i_gpio1_out(gp[31:16]), .i_gpio1_dir(gp[15:0]), .i_addr_data_port_in(adp),
        .i_address_port_in(ap), .o_addr_data_port_out(ado), .o_addr_data_port_oe(adoe),
        .o_address_port_out(ao), .o_address_port_oe(aoe), .o_addr_data_port_sync(ads),
        .o_address_port_sync(as_s), .o_bus_rdata(rd), .o_high_byte_enable_n(hbe_n));
    ext_mem_model u_mem (.i_clk_sys(i_clk_sys), .i_ad_out(ado), .i_ad_oe(adoe),
        .i_a_out(ao), .i_a_oe(aoe), .o_ad_pin(adp), .o_a_pin(ap));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // {ad out, ad oe, addr out, addr oe} one edge after these inputs
    function automatic logic [63:0] exp_pins(input ext_bus_pins_pkg::bus_cfg_t c,
        input ext_bus_pins_pkg::bus_req_t r, input logic h, input logic [63:0] g);
        logic [15:0] o, oe;
        logic dm, mx;
        dm = c.mode == 2'h1;
        mx = c.mode == 2'h2;
        o = (dm | mx) ? ((mx & r.addr_phase) ? r.addr : r.wdata) : g[63:48];
        oe = (dm | mx) ? {16{(mx & r.addr_phase) | r.drive_data}} : g[47:32];
        // narrow bus: high half is gpio in demux, fixed address in mux
        if ((dm | mx) & !c.wide) begin
            o[15:8] = mx ? r.addr[15:8] : g[63:56];
            oe[15:8] = mx ? 8'hff : g[47:40];
        end
        return (dm | (mx & h)) ? {o, oe, r.addr, 16'hffff} : {o, oe, g[31:0]};
    endfunction
    // one cycle: predict from sampled inputs, apply next inputs, check outputs
    task automatic step(input logic [2:0] c, input logic [34:0] r, input logic rnd);
        logic [63:0] e;
        logic eb;
        @(posedge i_clk_sys);
        e = exp_pins(cfg, req, hold_m, gp);
        eb = ~(cfg.wide & req.high_byte & (cfg.mode == 2'h1 | cfg.mode == 2'h2));
        hold_m = cfg.mode == 2'h1 | (hold_m & cfg.mode == 2'h2);
        cfg <= rnd ? 3'($urandom) : c;
        req <= rnd ? 35'({$urandom, $urandom}) : r;
        if (rnd) gp <= {$urandom, $urandom};
        @(negedge i_clk_sys);
        chk(adoe, e[47:32]);
        chk(ado & e[47:32], e[63:48] & e[47:32]);
        chk(aoe, e[15:0]);
        chk(ao & e[15:0], e[31:16] & e[15:0]);
        chk({15'h0, hbe_n}, {15'h0, eb});
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hbce6));
        repeat (6) @(posedge i_clk_sys);
        chk(adoe | aoe, 16'h0000);
        i_sys_rst <= 1'b0;
        // demux, then mux narrow and wide: address port keeps the address
        step(3'h2, {16'h1234, 16'h00a5, 3'h2}, 1'b0);
        step(3'h4, {16'h1234, 16'h00a5, 3'h4}, 1'b0);
        step(3'h5, {16'hbeef, 16'hc3a5, 3'h3}, 1'b0);
        repeat (2) step(3'h0, 35'h0, 1'b0);
        $display("test hold done");
        // wide demux read held long enough to pass the synchronisers
        repeat (8) step(3'h3, {16'h0f1e, 16'h0000, 3'h1}, 1'b0);
        chk(rd, 16'h0f1e ^ 16'h5a5a);
        chk(ads, 16'h0f1e ^ 16'h5a5a);
        chk(as_s, 16'h0f1e);
        $display("test read done");
        // narrow demux read of a new word: upper read byte comes back as zero
        repeat (8) step(3'h2, {16'h3c87, 16'h0000, 3'h0}, 1'b0);
        chk(rd, (16'h3c87 ^ 16'h5a5a) & 16'h00ff);
        chk(as_s, 16'h3c87);
        $display("test narrow read done");
        repeat (3000) step(3'h0, 35'h0, 1'b1);
        $display("test random done");
        // reset in mid-run drops every driver and the hold
        @(posedge i_clk_sys);
        i_sys_rst <= 1'b1;
        @(negedge i_clk_sys);
        chk(adoe | aoe, 16'h0000);
        chk({15'h0, hbe_n}, 16'h0001);
        hold_m = 1'b0;
        @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        repeat (1000) step(3'h0, 35'h0, 1'b1);
        $display("test reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
